//--- usart_sync_slave_transmit.sv
// synchronous slave transmit path of the serial transceiver: APB registers,
// holding register and the crossing to the externally clocked shifter.
// assumes: APB master on pclk; shift clock from the external master on its
// own clock port; the core's sleep gates nothing here.
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
module usart_sync_slave_transmit
  import usart_tx_pkg::*;
(
  // system clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // shift clock pin, clock of the link domain
  input wire logic shift_clock_pin,
  output logic shift_clock_oe,
  // data pin
  input wire logic data_pin_in,
  output logic data_pin_out,
  output logic data_pin_oe,
  // towards the core
  output logic wake_request,
  output logic irq_request,
  output logic [12:0] irq_vector
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [7:0] interrupt_control;
    logic [7:0] periph_flags_one;
    logic [7:0] receive_status_control;
    logic [7:0] periph_enable_one;
    logic [7:0] transmit_status_control;
    logic [7:0] baud_rate_divisor;
    logic [8:0] hold_word;
    logic hold_nine;
    logic hold_full;
    logic pending;
    logic req_tog;
    logic ack_s1;
    logic ack_s2;
    logic ack_prev;
    logic busy_s1;
    logic busy_s2;
    logic wake;
    logic irq;
    logic [12:0] vector;
    logic [DATA_W-1:0] rdata;
    logic rerr;
  } main_state_t;

  main_state_t s;
  main_state_t next_s;

  // ==========================================================================
  // link-side wires
  logic ack_tog;
  logic eng_busy;

  // ==========================================================================
  // derived control
  logic ack_edge;
  logic tx_ready;
  logic tx_flag;
  logic [7:0] tx_status_view;
  logic [7:0] flags_view;
  logic bus_setup;
  logic bus_write;
  logic [7:0] reg_index;
  logic addr_aligned;

  // slave mode only when clock source select is clear
  assign tx_ready = s.transmit_status_control[BIT_SYNC_SELECT]
    && !s.transmit_status_control[BIT_CLOCK_SOURCE]
    && s.transmit_status_control[BIT_TX_ENABLE]
    && s.receive_status_control[BIT_SERIAL_PORT_ENABLE];

  // toggle back from the link marks the word taken into the shifter
  assign ack_edge = (s.ack_s2 != s.ack_prev);

  // flag reads as holding empty; cleared while a word waits
  assign tx_flag = s.transmit_status_control[BIT_TX_ENABLE]
    && !s.hold_full;

  // shifter-empty status sits in bit 1; bit 3 reads zero
  always_comb begin
    tx_status_view = s.transmit_status_control;
    tx_status_view[BIT_UNUSED_TXSC] = 1'b0;
    tx_status_view[BIT_SHIFTER_EMPTY] = !s.busy_s2;
  end

  // flag register shows the live transmit flag in bit 4
  always_comb begin
    flags_view = s.periph_flags_one;
    flags_view[BIT_TX_IRQ] = tx_flag;
  end

  // APB phases; the access phase always completes in one cycle
  assign bus_setup = psel && !penable;
  assign bus_write = psel && penable && pwrite;
  assign reg_index = paddr[9:2];
  assign addr_aligned = (paddr[1:0] == 2'b00);

  // ==========================================================================
  // next state
  always_comb begin
    next_s = s;

    // crossings back from the link domain, two flops each
    next_s.ack_s1 = ack_tog;
    next_s.ack_s2 = s.ack_s1;
    next_s.ack_prev = s.ack_s2;
    next_s.busy_s1 = eng_busy;
    next_s.busy_s2 = s.busy_s1;

    // word has moved into the shifter: holding is free again
    if (ack_edge) begin
      next_s.pending = 1'b0;
      next_s.hold_full = 1'b0;
    end

    // hand the holding word across; the shifter picks it up as its last bit ends or while idle
    if (s.hold_full && !s.pending && tx_ready) begin
      next_s.pending = 1'b1;
      next_s.req_tog = ~s.req_tog;
    end

    // read data and error prepared in the setup phase, shown in access
    if (bus_setup) begin
      next_s.rdata = '0;
      next_s.rerr = 1'b0;
      if (!addr_aligned) begin
        next_s.rerr = 1'b1;
      end else begin
        unique case (reg_index)
          IDX_INTERRUPT_CONTROL: begin
            next_s.rdata[7:0] = s.interrupt_control;
          end
          IDX_PERIPH_FLAGS_ONE: begin
            next_s.rdata[7:0] = flags_view;
          end
          IDX_RECEIVE_STATUS_CONTROL: begin
            next_s.rdata[7:0] = s.receive_status_control;
          end
          IDX_TRANSMIT_HOLDING: begin
            // write-only: reads as zero
            next_s.rdata[7:0] = RST_ZERO;
          end
          IDX_PERIPH_ENABLE_ONE: begin
            next_s.rdata[7:0] = s.periph_enable_one;
          end
          IDX_TRANSMIT_STATUS_CONTROL: begin
            next_s.rdata[7:0] = tx_status_view;
          end
          IDX_BAUD_RATE_DIVISOR: begin
            next_s.rdata[7:0] = s.baud_rate_divisor;
          end
          default: begin
            next_s.rerr = 1'b1;
          end
        endcase
      end
    end

    // writes take effect at the completing access edge
    if (bus_write && addr_aligned) begin
      unique case (reg_index)
        IDX_INTERRUPT_CONTROL: begin
          next_s.interrupt_control = pwdata[7:0];
        end
        IDX_PERIPH_FLAGS_ONE: begin
          // transmit flag is hardware-owned; other bits are plain storage
          next_s.periph_flags_one = pwdata[7:0];
          next_s.periph_flags_one[BIT_TX_IRQ] = 1'b0;
        end
        IDX_RECEIVE_STATUS_CONTROL: begin
          next_s.receive_status_control = pwdata[7:0];
        end
        IDX_TRANSMIT_HOLDING: begin
          // a word already handed across cannot be replaced, since the
          // link may be copying it at any moment; once the shifter takes
          // it in this very cycle the new word is kept (set wins)
          if (!s.pending || ack_edge) begin
            next_s.hold_word = {
              s.transmit_status_control[BIT_NINTH_TX_DATA], pwdata[7:0]};
            next_s.hold_nine = s.transmit_status_control[BIT_NINE_BIT_TX];
            next_s.hold_full = 1'b1;
          end
        end
        IDX_PERIPH_ENABLE_ONE: begin
          next_s.periph_enable_one = pwdata[7:0];
        end
        IDX_TRANSMIT_STATUS_CONTROL: begin
          next_s.transmit_status_control =
            (pwdata[7:0] & TX_STATUS_WMASK)
            | (RST_TRANSMIT_STATUS & ~TX_STATUS_WMASK);
        end
        IDX_BAUD_RATE_DIVISOR: begin
          // kept for software; the slave never divides its own clock
          next_s.baud_rate_divisor = pwdata[7:0];
        end
        default: begin
          next_s.interrupt_control = s.interrupt_control;
        end
      endcase
    end

    // wake and vector follow the flag; registered so the core sees clean
    // levels
    next_s.wake = tx_flag && s.periph_enable_one[BIT_TX_IRQ];
    next_s.irq = next_s.wake
      && s.interrupt_control[BIT_GLOBAL_IRQ_ENABLE]
      && s.interrupt_control[BIT_PERIPH_IRQ_MASTER];
    next_s.vector = next_s.irq ? IRQ_VECTOR : NO_VECTOR;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.transmit_status_control <= RST_TRANSMIT_STATUS;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // link-domain shifter; the request word is stable while pending is high
  tx_shift_engine u_engine (
    .shift_clk(shift_clock_pin),
    .presetn(presetn),
    .req_tog(s.req_tog),
    .req_word(s.hold_word),
    .req_nine(s.hold_nine),
    .ack_tog(ack_tog),
    .busy(eng_busy),
    .data_out(data_pin_out),
    .data_oe(data_pin_oe)
  );

  // ==========================================================================
  // outputs
  // the slave never drives the clock pin; data input unused when sending
  assign shift_clock_oe = 1'b0;
  assign pready = psel && penable;
  assign prdata = s.rdata;
  assign pslverr = s.rerr && psel && penable;
  assign wake_request = s.wake;
  assign irq_request = s.irq;
  assign irq_vector = s.vector;

  // ==========================================================================
  // checks
  a_clock_not_driven: assert property (@(posedge pclk) disable iff (!presetn)
    !shift_clock_oe)
    else $error("clock pin driven in slave mode");

  a_master_no_request: assert property (@(posedge pclk)
    disable iff (!presetn)
    $rose(s.pending) |-> !$past(s.transmit_status_control[BIT_CLOCK_SOURCE]))
    else $error("word handed over with clock source select set");

  a_request_stable: assert property (@(posedge pclk) disable iff (!presetn)
    s.pending && !ack_edge |=> s.pending && $stable(s.hold_word)
      && $stable(s.req_tog))
    else $error("request changed while in flight");

  a_word_goes_at_once: assert property (@(posedge pclk)
    disable iff (!presetn)
    s.hold_full && !s.pending && tx_ready
      |=> s.pending && (s.req_tog != $past(s.req_tog)))
    else $error("holding word not handed to shifter");

  a_flag_held_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s.hold_full |-> (!tx_flag && !flags_view[BIT_TX_IRQ])
      ##1 !wake_request)
    else $error("transmit flag set while word waits");

  a_flag_after_move: assert property (@(posedge pclk) disable iff (!presetn)
    ack_edge && s.transmit_status_control[BIT_TX_ENABLE]
      && !bus_write |=> !s.hold_full && tx_flag)
    else $error("flag not set after word moved");

  a_wake_on_flag: assert property (@(posedge pclk) disable iff (!presetn)
    tx_flag && s.periph_enable_one[BIT_TX_IRQ]
      |=> wake_request && (irq_request
        == ($past(s.interrupt_control[BIT_GLOBAL_IRQ_ENABLE])
          && $past(s.interrupt_control[BIT_PERIPH_IRQ_MASTER]))))
    else $error("wake or branch missing after flag");

  a_vector_value: assert property (@(posedge pclk) disable iff (!presetn)
    irq_request |-> irq_vector == IRQ_VECTOR && wake_request)
    else $error("wrong interrupt vector");

  a_reload_when_free: assert property (@(posedge pclk)
    disable iff (!presetn)
    $fell(s.pending) |-> $past(ack_edge))
    else $error("holding released without shifter taking it");

  a_hold_write_kept: assert property (@(posedge pclk)
    disable iff (!presetn)
    ack_edge && bus_write && addr_aligned
      && reg_index == IDX_TRANSMIT_HOLDING |=> s.hold_full)
    else $error("word written as the shifter took the last one was lost");

  a_no_handover_idle: assert property (@(posedge pclk)
    disable iff (!presetn)
    !tx_ready |=> $stable(s.req_tog))
    else $error("word handed over while slave transmit is off");

  a_vector_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !irq_request |-> irq_vector == NO_VECTOR)
    else $error("vector shown without a branch request");

  a_wake_needs_enable: assert property (@(posedge pclk)
    disable iff (!presetn)
    !(tx_flag && s.periph_enable_one[BIT_TX_IRQ]) |=> !wake_request)
    else $error("wake raised without flag and enable");

  a_flag_read_live: assert property (@(posedge pclk)
    disable iff (!presetn)
    bus_setup && addr_aligned && reg_index == IDX_PERIPH_FLAGS_ONE
      |=> prdata[BIT_TX_IRQ] == $past(tx_flag))
    else $error("flag register read does not show the flag");

endmodule

//--- usart_tx_pkg.sv
// package for the synchronous slave transmit path of the serial transceiver
// assumes: registers sit one per aligned 32-bit word on an APB bus,
// the byte address being four times the register index.
package usart_tx_pkg;

  // ==========================================================================
  // bus geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;

  // ==========================================================================
  // register indices (byte address = index * 4)
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
  localparam logic [7:0] IDX_PERIPH_FLAGS_ONE = 8'h0c;
  localparam logic [7:0] IDX_RECEIVE_STATUS_CONTROL = 8'h18;
  localparam logic [7:0] IDX_TRANSMIT_HOLDING = 8'h19;
  localparam logic [7:0] IDX_PERIPH_ENABLE_ONE = 8'h8c;
  localparam logic [7:0] IDX_TRANSMIT_STATUS_CONTROL = 8'h98;
  localparam logic [7:0] IDX_BAUD_RATE_DIVISOR = 8'h99;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_STATUS = 8'h02;

  // ==========================================================================
  // transmit status and control fields
  localparam int BIT_CLOCK_SOURCE = 7;
  localparam int BIT_NINE_BIT_TX = 6;
  localparam int BIT_TX_ENABLE = 5;
  localparam int BIT_SYNC_SELECT = 4;
  localparam int BIT_UNUSED_TXSC = 3;
  localparam int BIT_SHIFTER_EMPTY = 1;
  localparam int BIT_NINTH_TX_DATA = 0;
  // bit 3 unimplemented, bit 1 read-only
  localparam logic [7:0] TX_STATUS_WMASK = 8'hf5;

  // ==========================================================================
  // receive status, interrupt control, flag and enable fields
  localparam int BIT_SERIAL_PORT_ENABLE = 7;
  localparam int BIT_SINGLE_RX_ENABLE = 5;
  localparam int BIT_CONT_RX_ENABLE = 4;
  localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
  localparam int BIT_PERIPH_IRQ_MASTER = 6;
  localparam int BIT_TX_IRQ = 4;

  // ==========================================================================
  // word lengths and the interrupt vector handed to the core
  localparam logic [3:0] WORD_BITS_EIGHT = 4'd8;
  localparam logic [3:0] WORD_BITS_NINE = 4'd9;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [12:0] NO_VECTOR = 13'h0000;

endpackage

//--- tx_shift_engine.sv
// shift register and bit counter running on the externally supplied clock
// assumes: the request word is held stable while its toggle is in flight,
// and the master keeps clocking while a word is being shifted.
`timescale 1ns/10ps
module tx_shift_engine
  import usart_tx_pkg::*;
(
  // link clock and reset
  input wire logic shift_clk,
  input wire logic presetn,
  // request from the register domain
  input wire logic req_tog,
  input wire logic [8:0] req_word,
  input wire logic req_nine,
  // answer to the register domain
  output logic ack_tog,
  output logic busy,
  // data pin drive
  output logic data_out,
  output logic data_oe
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic [8:0] shifter;
    logic [3:0] count;
    logic ack;
  } eng_state_t;

  eng_state_t s;
  eng_state_t next_s;

  // ==========================================================================
  // shift one bit per clock, reload only when the last bit is done
  always_comb begin
    next_s = s;
    next_s.req_s1 = req_tog;
    next_s.req_s2 = s.req_s1;
    if (s.count > 4'd1) begin
      next_s.shifter = s.shifter >> 1;
      next_s.count = s.count - 4'd1;
    end else if (s.req_s2 != s.req_seen) begin
      // back-to-back: next word replaces the last bit with no gap
      next_s.shifter = req_word;
      next_s.count = req_nine ? WORD_BITS_NINE : WORD_BITS_EIGHT;
      next_s.req_seen = s.req_s2;
      next_s.ack = ~s.ack;
    end else begin
      next_s.count = 4'd0;
    end
  end

  // no clock enable: sleep of the core never reaches this domain
  always_ff @(posedge shift_clk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ack_tog = s.ack;
  assign busy = (s.count != 4'd0);
  assign data_out = s.shifter[0];
  assign data_oe = (s.count != 4'd0);

  // ==========================================================================
  // checks
  a_bit_per_clock: assert property (@(posedge shift_clk) disable iff (!presetn)
    s.count > 4'd1 |=> s.count == $past(s.count) - 4'd1
      && s.shifter == ($past(s.shifter) >> 1))
    else $error("shifter did not advance one bit");
  a_no_stall_mid: assert property (@(posedge shift_clk) disable iff (!presetn)
    s.count > 4'd1 |=> data_oe)
    else $error("shifting stopped inside a word");
  a_reload_only_empty: assert property (@(posedge shift_clk)
    disable iff (!presetn)
    s.count > 4'd1 |=> s.req_seen == $past(s.req_seen))
    else $error("shifter reloaded before its word was out");
  a_word_length: assert property (@(posedge shift_clk) disable iff (!presetn)
    $changed(s.ack) |-> s.count == WORD_BITS_EIGHT
      || s.count == WORD_BITS_NINE)
    else $error("loaded word has an illegal bit count");

endmodule

//--- shift_master_model.sv
// external synchronous master: makes the shift clock, captures data
// assumes: the bench raises run only around a frame, clock rests low
`timescale 1ns/10ps
module shift_master_model (
  // control from the bench
  input wire logic run,
  input wire logic presetn,
  // pins
  output logic shift_clk,
  input wire logic data_out,
  input wire logic data_oe,
  output logic data_line,
  // captured bits, lsb of each word first
  output logic [63:0] rx_bits,
  output logic [5:0] rx_count
);
  logic last_bit = 1'b0;
  // ==========================================================================
  // clock source: odd start offset keeps it unrelated to the bus clock
  initial begin
    shift_clk = 1'b0;
    #3.3;
    forever begin
      if (run) begin
        #7.5 shift_clk = 1'b1;
        #7.5 shift_clk = 1'b0;
      end else begin
        #1;
      end
    end
  end
  // released line shows the inverse of the last bit, never a held value
  always @(data_out or data_oe) begin
    if (data_oe) begin
      last_bit = data_out;
    end
  end
  assign data_line = data_oe ? data_out : ~last_bit;
  // ==========================================================================
  // capture on the falling edge, one bit per clock period
  always @(negedge shift_clk or negedge presetn) begin
    if (!presetn) begin
      rx_bits <= '0;
      rx_count <= '0;
    end else if (data_oe) begin
      rx_bits[rx_count] <= data_line;
      rx_count <= rx_count + 6'd1;
    end
  end
endmodule

//--- test_usart_sync_slave_transmit.sv
// self-checking bench for the synchronous slave transmit path
// assumes: shift_master_model as far side, APB master tasks here
`timescale 1ns/10ps
module test_usart_sync_slave_transmit;
  import usart_tx_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, run;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic shift_clk, shift_clock_oe, data_line, data_pin_out, data_pin_oe;
  logic wake_request, irq_request;
  logic [12:0] irq_vector;
  logic [63:0] rx_bits;
  logic [5:0] rx_count;
  int errors = 0;
  int checks_done = 0;
  localparam logic [7:0] IDX_TAB [8] = '{IDX_INTERRUPT_CONTROL,
    IDX_PERIPH_FLAGS_ONE, IDX_RECEIVE_STATUS_CONTROL, IDX_TRANSMIT_HOLDING,
    IDX_PERIPH_ENABLE_ONE, IDX_TRANSMIT_STATUS_CONTROL,
    IDX_BAUD_RATE_DIVISOR, 8'h01};
  localparam logic [7:0] RST_TAB [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h02, 8'h00, 8'h00};

  // ==========================================================================
  // instances
  usart_sync_slave_transmit i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shift_clock_pin(shift_clk), .shift_clock_oe(shift_clock_oe),
    .data_pin_in(data_line), .data_pin_out(data_pin_out),
    .data_pin_oe(data_pin_oe), .wake_request(wake_request),
    .irq_request(irq_request), .irq_vector(irq_vector));
  shift_master_model i_master (.run(run), .presetn(presetn),
    .shift_clk(shift_clk), .data_out(data_pin_out), .data_oe(data_pin_oe),
    .data_line(data_line), .rx_bits(rx_bits), .rx_count(rx_count));

  // ==========================================================================
  // shared tasks
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_wake(input logic v);
    int k;
    k = 0;
    while (wake_request !== v && k < 400) begin
      @(posedge pclk);
      k++;
    end
    check("wake_request", 32'(v), 32'(wake_request));
  endtask
  task automatic wait_count(input logic [5:0] n);
    int k;
    k = 0;
    while (rx_count !== n && k < 400) begin
      @(posedge pclk);
      k++;
    end
    check("rx_count", 32'(n), 32'(rx_count));
  endtask
  task automatic stop_clock();
    repeat (12) @(posedge pclk);
    run <= 1'b0;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset_values();
    logic [31:0] rd;
    logic err;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, IDX_TAB[i], 8'h00, rd, err);
      check("reset value", 32'(RST_TAB[i]), rd);
      check("pslverr", 32'(i == 7), 32'(err));
    end
    apb(1'b1, IDX_BAUD_RATE_DIVISOR, 8'ha5, rd, err);
    apb(1'b0, IDX_BAUD_RATE_DIVISOR, 8'h00, rd, err);
    check("baud divisor", 32'h0000_00a5, rd);
    check("clock oe", 32'h0, 32'(shift_clock_oe));
    $display("test reset_values done");
  endtask
  // two words back to back: second waits, flag only after first ends
  task automatic t_two_words();
    logic [31:0] rd;
    logic err;
    logic [5:0] base;
    base = rx_count;
    apb(1'b1, IDX_RECEIVE_STATUS_CONTROL, 8'h80, rd, err);
    apb(1'b1, IDX_PERIPH_ENABLE_ONE, 8'h10, rd, err);
    apb(1'b1, IDX_INTERRUPT_CONTROL, 8'hc0, rd, err);
    apb(1'b1, IDX_TRANSMIT_STATUS_CONTROL, 8'h30, rd, err);
    run <= 1'b1;
    apb(1'b1, IDX_TRANSMIT_HOLDING, 8'h96, rd, err);
    repeat (3) @(posedge pclk);
    wait_wake(1'b1);
    apb(1'b1, IDX_TRANSMIT_HOLDING, 8'h3c, rd, err);
    repeat (3) @(posedge pclk);
    check("flag with word waiting", 32'h0, 32'(wake_request));
    repeat (10) @(posedge pclk);
    check("flag still clear", 32'h0, 32'(wake_request));
    wait_wake(1'b1);
    check("first word out", 32'h1, 32'(rx_count - base >= 8));
    check("irq_request", 32'h1, 32'(irq_request));
    check("irq_vector", 32'(IRQ_VECTOR), 32'(irq_vector));
    apb(1'b0, IDX_PERIPH_FLAGS_ONE, 8'h00, rd, err);
    check("flag register", 32'h0000_0010, rd);
    wait_count(base + 6'd16);
    check("first word", 32'h96, 32'(rx_bits[base +: 8]));
    check("second word", 32'h3c, 32'(rx_bits[base + 6'd8 +: 8]));
    stop_clock();
    apb(1'b0, IDX_TRANSMIT_STATUS_CONTROL, 8'h00, rd, err);
    check("shifter empty", 32'h0000_0032, rd);
    $display("test two_words done");
  endtask
  // nine-bit word: ninth bit follows the eight data bits
  task automatic t_nine_bit();
    logic [31:0] rd;
    logic err;
    logic [5:0] base;
    base = rx_count;
    apb(1'b1, IDX_TRANSMIT_STATUS_CONTROL, 8'h71, rd, err);
    run <= 1'b1;
    apb(1'b1, IDX_TRANSMIT_HOLDING, 8'h5a, rd, err);
    wait_count(base + 6'd9);
    check("nine-bit word", 32'h15a, 32'(rx_bits[base +: 9]));
    stop_clock();
    $display("test nine_bit done");
  endtask
  // clock source set: no slave transfer may start
  task automatic t_master_select();
    logic [31:0] rd;
    logic err;
    logic [5:0] base;
    base = rx_count;
    apb(1'b1, IDX_TRANSMIT_STATUS_CONTROL, 8'hb0, rd, err);
    run <= 1'b1;
    apb(1'b1, IDX_TRANSMIT_HOLDING, 8'hff, rd, err);
    repeat (60) @(posedge pclk);
    check("no bits", 32'(base), 32'(rx_count));
    check("data oe", 32'h0, 32'(data_pin_oe));
    check("clock oe", 32'h0, 32'(shift_clock_oe));
    stop_clock();
    $display("test master_select done");
  endtask

  // ==========================================================================
  // verdict, clock, watchdog and main sequence
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // whole run needs under 300 cycles; twenty times that is a hang
  initial begin
    #30000;
    errors++;
    $display("watchdog expired");
    results();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    run = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_two_words();
    t_nine_bit();
    t_master_select();
    results();
  end
endmodule
